//--- hw/pmicre_defs.svh
// Offsets, field positions, reset values and voltage figures of the rail enable register bank.
//
// Notes on behaviour
// RULE_01: Bits seven and six of the second switch register are read-only and read as zero.
// RULE_02: Bit five of the second switch register selects plain load switch (0) or linear output (1).
// RULE_03: The five-bit code maps 1.5 V to 3.3 V in 50 mV steps, but codes 9 to 13 step 100 mV.
// RULE_04: The rail-enable register at 0x16 resets to zero and its bit seven is read-only.
// RULE_05: Bit six turns on the first switch only while the power-enable pin is high.
// RULE_06: Bit five turns on the second switch only while the power-enable pin is high.
// RULE_07: Bits four to two enable the three bucks and bits one and zero the two linear outputs.
// RULE_08: A set buck enable only turns its converter on while the power-enable pin is high.
// RULE_09: Writes to all three registers are accepted only while the password unlock holds.
// RULE_10: The lockout register at 0x18 resets to 0x03, bits 7 to 3 read-only, bits 2 to 0 writable.
// RULE_11: Writes to read-only reserved bits are ignored and those bits keep reading zero.
`ifndef PMICRE_DEFS_SVH
`define PMICRE_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PMICRE_ADDR_SW2 8'h15
`define PMICRE_ADDR_RAIL 8'h16
`define PMICRE_ADDR_UVLO 8'h18

// ----------------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------------
`define PMICRE_SW2_RESET 6'h3f
`define PMICRE_RAIL_RESET 7'h00
`define PMICRE_UVLO_RESET 3'h3
`define PMICRE_SW2_MODE_BIT 5
`define PMICRE_RAIL_SW1_BIT 6
`define PMICRE_RAIL_SW2_BIT 5
`define PMICRE_RAIL_BUCK1_BIT 4
`define PMICRE_RAIL_BUCK2_BIT 3
`define PMICRE_RAIL_BUCK3_BIT 2
`define PMICRE_RAIL_LIN1_BIT 1
`define PMICRE_RAIL_LIN2_BIT 0

// ----------------------------------------------------------------------------
// Output voltage code figures, in millivolts
// ----------------------------------------------------------------------------
`define PMICRE_MV_BASE 12'h5dc
`define PMICRE_MV_FINE 12'h032
`define PMICRE_MV_COARSE 12'h064
`define PMICRE_MV_COARSE_BASE 12'h7d0
`define PMICRE_MV_UPPER_BASE 12'h992
`define PMICRE_CODE_COARSE_LO 5'h09
`define PMICRE_CODE_COARSE_HI 5'h0d
`define PMICRE_CODE_UPPER_LO 5'h0e

`endif

//--- hw/pmicre_pkg.sv
// Types shared by the rail enable register bank.
package pmicre_pkg;

	typedef struct packed {
		logic switch_one_on;
		logic switch_two_on;
		logic buck_one_on;
		logic buck_two_on;
		logic buck_three_on;
		logic linear_one_on;
		logic linear_two_on;
	} pmicre_rails_t;

	typedef struct packed {
		logic [1:0] reserved;
		logic switch_two_regulator_select;
		logic [4:0] linear_four_voltage_code;
	} pmicre_sw2_t;

endpackage

//--- hw/pmicre_regs.sv
// Rail enable, second switch and lockout registers with pin-gated switch and buck rail drive.
`timescale 1ns/10ps
`include "pmicre_defs.svh"
module pmicre_regs (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic write_unlocked,
	input wire logic external_power_enable_pin,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output logic write_refused,
	output pmicre_pkg::pmicre_rails_t rails,
	output logic switch_two_regulator_select,
	output logic [4:0] linear_four_voltage_code,
	output logic [11:0] linear_four_mv,
	output logic [1:0] lockout_threshold_select,
	output logic lockout_spare_bit
);

	// ------------------------------------------------------------------------
	// Storage and decode
	// ------------------------------------------------------------------------
	logic [6:0] rail_enable_bits;
	logic [2:0] undervoltage_lockout_setting;
	logic pin_high;
	logic wr_ok;
	logic hit_sw2;
	logic hit_rail;
	logic hit_uvlo;
	logic [7:0] next_rdata;

	// The reset word is held at its own width so each field takes a slice of matching size.
	localparam logic [5:0] SW2_RESET_VALUE = `PMICRE_SW2_RESET;

	pmicre_sync u_pin_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(external_power_enable_pin),
		.sync_out(pin_high)
	);

	always_comb begin
		hit_sw2 = 1'b0;
		hit_rail = 1'b0;
		hit_uvlo = 1'b0;
		if (reg_addr == `PMICRE_ADDR_SW2) begin
			hit_sw2 = 1'b1;
		end else if (reg_addr == `PMICRE_ADDR_RAIL) begin
			hit_rail = 1'b1;
		end else if (reg_addr == `PMICRE_ADDR_UVLO) begin
			hit_uvlo = 1'b1;
		end
	end

	// A write without the password unlock is dropped whole, for any address.
	assign wr_ok = reg_wr && write_unlocked; // RULE_09

	// ------------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------------
	// Only the writable fields are stored, so reserved bits can never be set.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			switch_two_regulator_select <= SW2_RESET_VALUE[`PMICRE_SW2_MODE_BIT];
			linear_four_voltage_code <= SW2_RESET_VALUE[4:0];
		end else if (wr_ok && hit_sw2) begin
			switch_two_regulator_select <= reg_wdata[`PMICRE_SW2_MODE_BIT]; // RULE_02
			linear_four_voltage_code <= reg_wdata[4:0]; // RULE_03
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rail_enable_bits <= `PMICRE_RAIL_RESET; // RULE_04
		end else if (wr_ok && hit_rail) begin
			rail_enable_bits <= reg_wdata[6:0]; // RULE_11
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			undervoltage_lockout_setting <= `PMICRE_UVLO_RESET; // RULE_10
		end else if (wr_ok && hit_uvlo) begin
			undervoltage_lockout_setting <= reg_wdata[2:0]; // RULE_10
		end
	end

	assign lockout_threshold_select = undervoltage_lockout_setting[1:0];
	assign lockout_spare_bit = undervoltage_lockout_setting[2];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			write_refused <= 1'b0;
		end else begin
			write_refused <= reg_wr && !write_unlocked; // RULE_09
		end
	end

	// ------------------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------------------
	// Unmapped offsets read as zero rather than echoing stale data.
	always_comb begin
		next_rdata = 8'h00;
		if (hit_sw2) begin
			next_rdata = {2'b00, switch_two_regulator_select, linear_four_voltage_code}; // RULE_01
		end else if (hit_rail) begin
			next_rdata = {1'b0, rail_enable_bits}; // RULE_04
		end else if (hit_uvlo) begin
			next_rdata = {5'h00, undervoltage_lockout_setting}; // RULE_11
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : 8'h00;
			reg_rvalid <= reg_rd;
		end
	end

	// ------------------------------------------------------------------------
	// Rail drive
	// ------------------------------------------------------------------------
	// The linear outputs one and two are not tied to the pin; everything else is.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rails <= '0;
		end else begin
			rails.switch_one_on <= rail_enable_bits[`PMICRE_RAIL_SW1_BIT] && pin_high; // RULE_05
			rails.switch_two_on <= rail_enable_bits[`PMICRE_RAIL_SW2_BIT] && pin_high; // RULE_06
			rails.buck_one_on <= rail_enable_bits[`PMICRE_RAIL_BUCK1_BIT] && pin_high; // RULE_08
			rails.buck_two_on <= rail_enable_bits[`PMICRE_RAIL_BUCK2_BIT] && pin_high; // RULE_08
			rails.buck_three_on <= rail_enable_bits[`PMICRE_RAIL_BUCK3_BIT] && pin_high; // RULE_08
			rails.linear_one_on <= rail_enable_bits[`PMICRE_RAIL_LIN1_BIT]; // RULE_07
			rails.linear_two_on <= rail_enable_bits[`PMICRE_RAIL_LIN2_BIT]; // RULE_07
		end
	end

	// ------------------------------------------------------------------------
	// Output voltage decode
	// ------------------------------------------------------------------------
	// The code is decoded even in switch mode; the analog side ignores it there.
	function automatic logic [11:0] code_to_mv(input logic [4:0] code);
		logic [11:0] wide;
		wide = {7'h00, code};
		if (code < `PMICRE_CODE_COARSE_LO) begin
			code_to_mv = 12'(`PMICRE_MV_BASE + `PMICRE_MV_FINE * wide);
		end else if (code <= `PMICRE_CODE_COARSE_HI) begin
			code_to_mv = 12'(`PMICRE_MV_COARSE_BASE +
				`PMICRE_MV_COARSE * (wide - {7'h00, `PMICRE_CODE_COARSE_LO}));
		end else begin
			code_to_mv = 12'(`PMICRE_MV_UPPER_BASE +
				`PMICRE_MV_FINE * (wide - {7'h00, `PMICRE_CODE_UPPER_LO}));
		end
	endfunction

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			linear_four_mv <= 12'h000;
		end else begin
			linear_four_mv <= code_to_mv(linear_four_voltage_code); // RULE_03
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	chk_sw2_reserved_zero: assert property ( // RULE_01
		$past(reg_rd && hit_sw2) |-> reg_rdata[7:6] == 2'b00)
		else $error("Second switch reserved bits read nonzero.");

	chk_mode_bit_write: assert property ( // RULE_02
		(wr_ok && hit_sw2) |=> switch_two_regulator_select == $past(reg_wdata[5]))
		else $error("Mode select did not take the written bit.");

	chk_code_coarse_top: assert property ( // RULE_03
		(linear_four_voltage_code == 5'h0d) |=> linear_four_mv == 12'h960)
		else $error("Code 13 did not decode to 2400 mV.");

	chk_code_full_scale: assert property ( // RULE_03
		(linear_four_voltage_code == 5'h1f) |=> linear_four_mv == 12'hce4)
		else $error("Code 31 did not decode to 3300 mV.");

	chk_rail_read_top: assert property ( // RULE_04
		$past(reg_rd && hit_rail) |-> !reg_rdata[7])
		else $error("Rail enable bit seven read as one.");

	chk_switch_pin_gate: assert property ( // RULE_05
		!pin_high |=> !rails.switch_one_on && !rails.switch_two_on)
		else $error("A load switch drove with the pin low.");

	chk_buck_pin_gate: assert property ( // RULE_08
		!pin_high |=> !rails.buck_one_on && !rails.buck_two_on && !rails.buck_three_on)
		else $error("A buck drove with the pin low.");

	chk_buck_write_on: assert property ( // RULE_07
		(wr_ok && hit_rail && reg_wdata[4] && pin_high) ##1 pin_high |=> rails.buck_one_on)
		else $error("Buck one did not turn on two cycles after its write.");

	chk_linear_ungated: assert property ( // RULE_07
		(wr_ok && hit_rail) |=> ##1 rails.linear_two_on == $past(reg_wdata[0], 2))
		else $error("Linear two did not follow its enable.");

	chk_locked_write_drop: assert property ( // RULE_09
		(reg_wr && !write_unlocked) |=> write_refused && $stable(rail_enable_bits)
			&& $stable(undervoltage_lockout_setting) && $stable(linear_four_voltage_code))
		else $error("A locked write changed a register.");

	chk_uvlo_upper_zero: assert property ( // RULE_11
		$past(reg_rd && hit_uvlo) |-> reg_rdata[7:3] == 5'h00)
		else $error("Lockout reserved bits read nonzero.");

	cov_locked_write: cover property (reg_wr && !write_unlocked ##1 write_refused);
	cov_buck_on: cover property (pin_high && rail_enable_bits[4] ##1 rails.buck_one_on);
	cov_regulator_mode: cover property (wr_ok && hit_sw2 && reg_wdata[5]);
	cov_uvlo_read: cover property (reg_rd && hit_uvlo ##1 reg_rvalid);

endmodule

//--- hw/pmicre_sync.sv
// Two flip-flop synchroniser for a level arriving from a pin.
`timescale 1ns/10ps
module pmicre_sync (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic async_in,
	output logic sync_out
);

	logic stage_one;

	// The first stage feeds only the second one, so metastability cannot spread.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stage_one <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end

endmodule

//--- sim/pmicre_host_model.sv
// Host side model that drives the register strobes, the unlock level and the power pin.
`timescale 1ns/10ps
module pmicre_host_model (
	input wire logic sys_clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic write_unlocked,
	output logic external_power_enable_pin,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic write_refused
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		write_unlocked = 1'b1;
		external_power_enable_pin = 1'b0;
	end
	// -----------------------------------------------------------------------
	// Bus cycles
	// -----------------------------------------------------------------------
	// Released address and data lines are inverted, so a late sampler sees junk.
	task automatic bus_write(input logic [7:0] a, input logic [7:0] d, output logic refused);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		#1;
		refused = write_refused;
	endtask
	task automatic bus_read(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		v = reg_rvalid;
		d = reg_rdata;
	endtask
	// The unlock sequence itself lives outside; only its resulting level is modelled.
	task automatic set_unlock(input logic u);
		@(posedge sys_clk);
		write_unlocked <= u;
	endtask
	task automatic set_pin(input logic p);
		@(posedge sys_clk);
		external_power_enable_pin <= p;
	endtask
endmodule

//--- sim/test_pmic_rail_enable_config_regs.sv
// Self-checking testbench for the rail enable register bank.
`timescale 1ns/10ps
module test_pmic_rail_enable_config_regs;
	logic sys_clk, rst, reg_wr, reg_rd, write_unlocked, external_power_enable_pin;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_rvalid, write_refused, switch_two_regulator_select, lockout_spare_bit;
	pmicre_pkg::pmicre_rails_t rails;
	logic [4:0] linear_four_voltage_code;
	logic [11:0] linear_four_mv;
	logic [1:0] lockout_threshold_select;
	int n_errors = 0;
	int compares = 0;
	pmicre_regs i_pmicre_regs (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .write_unlocked(write_unlocked),
		.external_power_enable_pin(external_power_enable_pin), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .write_refused(write_refused), .rails(rails),
		.switch_two_regulator_select(switch_two_regulator_select),
		.linear_four_voltage_code(linear_four_voltage_code), .linear_four_mv(linear_four_mv),
		.lockout_threshold_select(lockout_threshold_select),
		.lockout_spare_bit(lockout_spare_bit));
	pmicre_host_model i_pmicre_host_model (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .write_unlocked(write_unlocked),
		.external_power_enable_pin(external_power_enable_pin), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .write_refused(write_refused));
	// -----------------------------------------------------------------------
	// Shared checks
	// -----------------------------------------------------------------------
	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic exp_ref);
		logic r;
		i_pmicre_host_model.bus_write(a, d, r);
		chk(r, exp_ref, "refused pulse");
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic v;
		i_pmicre_host_model.bus_read(a, d, v);
		chk(v, 1'b1, "read valid");
		chk(d, exp, "read data");
	endtask
	// -----------------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------------
	task automatic t_reset();
		rd(8'h15, 8'h3f);
		rd(8'h16, 8'h00);
		rd(8'h18, 8'h03);
		rd(8'h17, 8'h00);
		chk(rails, 12'h000, "rails after reset");
		chk(linear_four_mv, 12'hce4, "millivolts after reset");
		chk({lockout_spare_bit, lockout_threshold_select}, 12'h003, "lockout");
		$display("test reset values done");
	endtask
	task automatic t_sw2();
		int mv;
		wr(8'h15, 8'hff, 1'b0);
		rd(8'h15, 8'h3f);
		for (int c = 0; c < 32; c++) begin
			mv = c < 9 ? 1500 + 50 * c : c < 14 ? 2000 + 100 * (c - 9) : 2450 + 50 * (c - 14);
			wr(8'h15, {2'b00, c[0], c[4:0]}, 1'b0);
			@(posedge sys_clk);
			#1;
			chk(switch_two_regulator_select, c[0], "mode select");
			chk(linear_four_voltage_code, c[4:0], "voltage code");
			chk(linear_four_mv, mv[11:0], "millivolts");
		end
		$display("test second switch done");
	endtask
	task automatic t_rail();
		wr(8'h16, 8'hff, 1'b0);
		rd(8'h16, 8'h7f);
		repeat (4) @(posedge sys_clk);
		#1;
		chk(rails, 12'h003, "rails with pin low");
		i_pmicre_host_model.set_pin(1'b1);
		repeat (5) @(posedge sys_clk);
		#1;
		chk(rails, 12'h07f, "rails with pin high");
		for (int i = 0; i < 7; i++) begin
			wr(8'h16, 8'h01 << i, 1'b0);
			@(posedge sys_clk);
			#1;
			chk(rails, 12'h001 << i, "single rail");
		end
		$display("test rail enables done");
	endtask
	task automatic t_lock();
		i_pmicre_host_model.set_unlock(1'b0);
		wr(8'h18, 8'h00, 1'b1);
		rd(8'h18, 8'h03);
		i_pmicre_host_model.set_unlock(1'b1);
		wr(8'h18, 8'hff, 1'b0);
		rd(8'h18, 8'h07);
		chk({lockout_spare_bit, lockout_threshold_select}, 12'h007, "lockout");
		wr(8'h17, 8'hff, 1'b0);
		rd(8'h17, 8'h00);
		$display("test lockout and protection done");
	endtask
	// -----------------------------------------------------------------------
	// Run control
	// -----------------------------------------------------------------------
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		rst = 1'b1;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_sw2();
		t_rail();
		t_lock();
		final_report();
	end
	// The whole sequence takes well under a thousand cycles.
	initial begin
		#20000;
		n_errors++;
		final_report();
	end
endmodule
